//--- src/scrm_pkg.sv
package scrm_pkg;

  // ****************************************************************
  // address partition
  // ****************************************************************
  localparam int unsigned ADDR_W        = 9;
  localparam int unsigned DATA_W        = 8;
  localparam logic [8:0]  ADDR_PORT     = 9'h000;
  localparam logic [8:0]  ADDR_DEV_ID   = 9'h001;
  localparam logic [8:0]  ADDR_GRADE    = 9'h002;
  localparam logic [8:0]  ADDR_FUNC_LO  = 9'h008;
  localparam logic [8:0]  ADDR_SHAD_HI  = 9'h018;
  localparam logic [8:0]  ADDR_FUNC_HI  = 9'h030;
  localparam logic [8:0]  ADDR_APPLY    = 9'h0ff;
  localparam logic [8:0]  ADDR_FEATURE  = 9'h100;
  localparam int unsigned SHADOW_DEPTH  = 17;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned PS_LSB_HI     = 6;
  localparam int unsigned PS_LSB_LO     = 1;
  localparam int unsigned PS_SRST_HI    = 5;
  localparam int unsigned PS_SRST_LO    = 2;
  localparam int unsigned APPLY_BIT     = 0;
  localparam int unsigned GRADE_POS     = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  PORT_FIXED    = 8'h18;
  localparam logic [7:0]  PORT_RESET    = 8'h18;
  localparam logic [7:0]  APPLY_RESET   = 8'h00;
  localparam logic [7:0]  FEATURE_RESET = 8'h00;
  localparam logic [7:0]  DEV_ID_VALUE  = 8'h5a; // arbitrary value
  localparam logic [1:0]  GRADE_VALUE   = 2'h1;

  // defaults of the shadowed bank, indexed from address 0x08
  function automatic logic [7:0] scrm_shadow_default(input int unsigned idx);
    unique case (idx)
      0:       return 8'h80;
      1:       return 8'h01;
      6:       return 8'h04;
      16:      return 8'hc0;
      default: return 8'h00;
    endcase
  endfunction : scrm_shadow_default

endpackage : scrm_pkg

//--- src/scrm_shadow_bank.sv
`timescale 1ns/1ps
module scrm_shadow_bank
  import scrm_pkg::*;
#(
  parameter int unsigned DEPTH = SHADOW_DEPTH,
  parameter int unsigned W     = DATA_W
) (
  input  wire logic                 core_clk_in,
  input  wire logic                 rstn_in,
  input  wire logic                 wr_en_in,
  input  wire logic [4:0]           idx_in,
  input  wire logic [W-1:0]         wdata_in,
  input  wire logic                 apply_in,
  input  wire logic                 restore_in,
  output logic      [W-1:0]         staged_out,
  output logic      [DEPTH*W-1:0]   active_out
);

  logic [W-1:0] staged_reg [DEPTH];
  // one process per entry writes its own element, so no slice of a vector has two writers
  logic [W-1:0] active_reg [DEPTH];

  // ****************************************************************
  // one staging and one active copy per entry
  // ****************************************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    localparam logic [W-1:0] DFLT = W'(scrm_shadow_default(i));
    wire hit = wr_en_in && (idx_in == 5'(i));

    // host writes touch only the staging copy
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        staged_reg[i] <= DFLT;
      end else if (restore_in) begin
        staged_reg[i] <= DFLT;
      end else if (hit) begin
        staged_reg[i] <= wdata_in;
      end
    end

    // each active copy loads its staging copy on an edge where apply_in is high and restore_in is low
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        active_reg[i] <= DFLT;
      end else if (restore_in) begin
        active_reg[i] <= DFLT;
      end else if (apply_in) begin
        active_reg[i] <= staged_reg[i];
      end
    end

    // flattened view of the active copies, straight from the flops
    assign active_out[i*W +: W] = active_reg[i];
  end

  // read back shows the staged value, not the active one
  assign staged_out = (idx_in < 5'(DEPTH)) ? staged_reg[idx_in] : '0;

endmodule : scrm_shadow_bank

//--- src/scrm_regmap.sv
`timescale 1ns/1ps
// How it works
// - map setup, transfer, function, feature address ranges
// - writes at 0x08..0x18 only change staging copies
// - writing 0x01 to 0xFF applies all staged
// - transfer bit clears itself after the update
// - reset loads defaults, port 0x18, transfer 0x00
// - mirrored bit order and soft reset bits
// - serial shifts msb first until changed
module scrm_regmap
  import scrm_pkg::*;
#(
  parameter int unsigned DEPTH = SHADOW_DEPTH
) (
  input  wire logic                   core_clk_in,
  input  wire logic                   rstn_in,
  input  wire logic                   wr_en_in,
  input  wire logic                   rd_en_in,
  input  wire logic [ADDR_W-1:0]      addr_in,
  input  wire logic [DATA_W-1:0]      wdata_in,
  output logic      [DATA_W-1:0]      rdata_out,
  output logic                        rvalid_out,
  output logic                        lsb_first_out,
  output logic                        soft_reset_out,
  output logic                        apply_done_out,
  output logic      [DATA_W-1:0]      feature_out,
  output logic      [DEPTH*DATA_W-1:0] active_out
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (DEPTH != int'(ADDR_SHAD_HI - ADDR_FUNC_LO) + 1) begin : g_bad_depth
    $error("shadow depth must cover 0x08 to 0x18");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  logic                lsb_first_reg;
  logic                lsb_first_next;
  logic                soft_rst_reg;
  logic                soft_rst_next;
  logic                apply_reg;
  logic                apply_next;
  logic [DATA_W-1:0]   feature_reg;
  logic [DATA_W-1:0]   feature_next;
  logic [DATA_W-1:0]   rdata_reg;
  logic [DATA_W-1:0]   rdata_next;
  logic                rvalid_reg;
  logic                done_reg;
  logic [DATA_W-1:0]   staged_rd;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire        hit_port    = (addr_in == ADDR_PORT);
  wire        hit_id      = (addr_in == ADDR_DEV_ID);
  wire        hit_grade   = (addr_in == ADDR_GRADE);
  wire        hit_apply   = (addr_in == ADDR_APPLY);
  wire        hit_feature = (addr_in == ADDR_FEATURE);
  wire        hit_shadow  = (addr_in >= ADDR_FUNC_LO) && (addr_in <= ADDR_SHAD_HI);
  wire [4:0]  shadow_idx  = 5'(addr_in - ADDR_FUNC_LO);

  // a soft reset swallows any write landing in the same cycle
  wire        wr_ok       = wr_en_in && !soft_rst_reg;
  wire        wr_port     = wr_ok && hit_port;
  wire        wr_apply    = wr_ok && hit_apply;
  wire        wr_feature  = wr_ok && hit_feature;
  wire        wr_shadow   = wr_ok && hit_shadow;

  // either mirror position sets a bit, so shift order does not matter
  wire        wr_lsb      = wdata_in[PS_LSB_HI] | wdata_in[PS_LSB_LO];
  wire        wr_srst     = wdata_in[PS_SRST_HI] | wdata_in[PS_SRST_LO];

  // ****************************************************************
  // port setup, transfer and feature next values
  // ****************************************************************
  // bit order stays msb first until the host asks otherwise
  assign lsb_first_next = soft_rst_reg ? 1'b0
                        : wr_port      ? wr_lsb
                        : lsb_first_reg;

  // soft reset lasts one cycle, then drops by itself
  assign soft_rst_next  = wr_port && wr_srst;

  // a fresh request wins over the self-clear of an earlier one
  assign apply_next     = soft_rst_reg ? 1'b0
                        : wr_apply     ? wdata_in[APPLY_BIT]
                        : 1'b0;

  assign feature_next   = soft_rst_reg ? FEATURE_RESET
                        : wr_feature   ? wdata_in
                        : feature_reg;

  // ****************************************************************
  // read mux
  // ****************************************************************
  // the port byte is rebuilt mirrored; fixed ones at bits 4 and 3
  wire [DATA_W-1:0] port_view  = PORT_FIXED
                               | (DATA_W'(lsb_first_reg) << PS_LSB_HI)
                               | (DATA_W'(lsb_first_reg) << PS_LSB_LO)
                               | (DATA_W'(soft_rst_reg)  << PS_SRST_HI)
                               | (DATA_W'(soft_rst_reg)  << PS_SRST_LO);
  wire [DATA_W-1:0] grade_view = DATA_W'(GRADE_VALUE) << GRADE_POS;
  wire [DATA_W-1:0] apply_view = DATA_W'(apply_reg) << APPLY_BIT;

  // unmapped addresses, including 0x19..0x30, read as zero
  assign rdata_next = hit_port    ? port_view
                    : hit_id      ? DEV_ID_VALUE
                    : hit_grade   ? grade_view
                    : hit_apply   ? apply_view
                    : hit_feature ? feature_reg
                    : hit_shadow  ? staged_rd
                    : '0;

  // ****************************************************************
  // shadowed function bank
  // ****************************************************************
  scrm_shadow_bank #(
    .DEPTH       (DEPTH),
    .W           (DATA_W)
  ) u_bank (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .wr_en_in    (wr_shadow),
    .idx_in      (shadow_idx),
    .wdata_in    (wdata_in),
    .apply_in    (apply_reg),
    .restore_in  (soft_rst_reg),
    .staged_out  (staged_rd),
    .active_out  (active_out)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  // control flops load their defaults on reset
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lsb_first_reg <= PORT_RESET[PS_LSB_LO];
      soft_rst_reg  <= PORT_RESET[PS_SRST_LO];
      apply_reg     <= APPLY_RESET[APPLY_BIT];
      feature_reg   <= FEATURE_RESET;
    end else begin
      lsb_first_reg <= lsb_first_next;
      soft_rst_reg  <= soft_rst_next;
      apply_reg     <= apply_next;
      feature_reg   <= feature_next;
    end
  end

  // read data is registered so it stays clean for the serialiser
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      rdata_reg  <= rd_en_in ? rdata_next : rdata_reg;
      rvalid_reg <= rd_en_in;
      done_reg   <= apply_reg && !soft_rst_reg;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata_out      = rdata_reg;
  assign rvalid_out     = rvalid_reg;
  assign lsb_first_out  = lsb_first_reg;
  assign soft_reset_out = soft_rst_reg;
  assign apply_done_out = done_reg;
  assign feature_out    = feature_reg;

endmodule : scrm_regmap

//--- dv/scrm_regmap_props.sv
`timescale 1ns/1ps
module scrm_regmap_props
  import scrm_pkg::*;
#(
  parameter int unsigned DEPTH = SHADOW_DEPTH
) (
  input wire logic                    core_clk_in,
  input wire logic                    rstn_in,
  input wire logic                    wr_en_in,
  input wire logic                    rd_en_in,
  input wire logic [ADDR_W-1:0]       addr_in,
  input wire logic [DATA_W-1:0]       wdata_in,
  input wire logic [DATA_W-1:0]       rdata_out,
  input wire logic                    rvalid_out,
  input wire logic                    lsb_first_out,
  input wire logic                    soft_reset_out,
  input wire logic                    apply_done_out,
  input wire logic [DATA_W-1:0]       feature_out,
  input wire logic [DEPTH*DATA_W-1:0] active_out
);
  // ****************************************
  // write decodes seen at the port
  // ****************************************
  wire apply_wr = wr_en_in && addr_in == ADDR_APPLY && wdata_in[0];
  wire srst_wr  = wr_en_in && addr_in == ADDR_PORT && (wdata_in[5] || wdata_in[2]);
  wire lsb_req  = wdata_in[6] || wdata_in[1];
  wire port_wr  = wr_en_in && addr_in == ADDR_PORT && !soft_reset_out && !srst_wr;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  // apply request that no soft reset cancels
  sequence s_apply_req;
    apply_wr && !soft_reset_out ##1 !soft_reset_out;
  endsequence

  a_read_answer: assert property (rd_en_in |=> rvalid_out)
    else $error("read not answered");
  a_no_stray_valid: assert property (!rd_en_in |=> !rvalid_out)
    else $error("stray read valid");
  a_apply_follows: assert property (s_apply_req |=> apply_done_out)
    else $error("apply missing");
  a_apply_cause: assert property ($rose(apply_done_out) |-> $past(apply_wr, 2))
    else $error("apply without request");
  a_staged_quiet: assert property (!apply_done_out && !soft_reset_out
    && !$past(soft_reset_out) |-> $stable(active_out)) else $error("active changed early");
  a_srst_cause: assert property ($rose(soft_reset_out) |-> $past(srst_wr))
    else $error("soft reset without request");
  a_srst_pulse: assert property (soft_reset_out |=> !soft_reset_out)
    else $error("soft reset too long");
  a_srst_defaults: assert property (soft_reset_out |=> !lsb_first_out
    && feature_out == FEATURE_RESET) else $error("defaults not restored");
  a_order_mirror: assert property (port_wr |=> lsb_first_out == $past(lsb_req))
    else $error("bit order not taken");
  a_port_fixed: assert property (rd_en_in && addr_in == ADDR_PORT |=> rdata_out[4:3] == 2'b11)
    else $error("port setup fixed ones missing");
endmodule : scrm_regmap_props

bind scrm_regmap scrm_regmap_props #(.DEPTH(DEPTH)) u_props (.core_clk_in, .rstn_in,
  .wr_en_in, .rd_en_in, .addr_in, .wdata_in, .rdata_out, .rvalid_out, .lsb_first_out,
  .soft_reset_out, .apply_done_out, .feature_out, .active_out);

//--- dv/scrm_host_model.sv
`timescale 1ns/1ps
module scrm_host_model
  import scrm_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic [DATA_W-1:0] rdata_in,
  input  wire logic              rvalid_in,
  output logic                   wr_en_out,
  output logic                   rd_en_out,
  output logic      [ADDR_W-1:0] addr_out,
  output logic      [DATA_W-1:0] wdata_out
);
  // ****************************************
  // byte access host
  // ****************************************
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out  = '0;
    wdata_out = '0;
  end

  // released bus is scrambled so stale values never look valid
  task automatic idle();
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out  = ~addr_out;
    wdata_out = ~wdata_out;
  endtask : idle

  // one byte write, unused bits forced low; writes to 0x013 are skipped
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    if (a == 9'h013) return;
    @(posedge core_clk_in) #1;
    addr_out  = a;
    wdata_out = (a == ADDR_APPLY) ? (d & 8'h01) : (a == ADDR_PORT) ? (d & 8'h7e) : d;
    wr_en_out = 1'b1;
    @(posedge core_clk_in) #1;
    idle();
  endtask : wr

  // one byte read, answer fixed one cycle later
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge core_clk_in) #1;
    addr_out  = a;
    rd_en_out = 1'b1;
    @(posedge core_clk_in) #1;
    idle();
    d = rvalid_in ? rdata_in : 8'hxx;
  endtask : rd
endmodule : scrm_host_model

//--- dv/shadowed_config_register_map_test.sv
`timescale 1ns/1ps
module shadowed_config_register_map_test;
  import scrm_pkg::*;
  logic                           core_clk_in;
  logic                           rstn_in;
  logic                           wr_en, rd_en, rvalid, lsb_first, soft_reset, apply_done;
  logic [ADDR_W-1:0]              addr;
  logic [DATA_W-1:0]              wdata, rdata, feature, rd_val;
  logic [SHADOW_DEPTH*DATA_W-1:0] active;
  int                             fail_count = 0;
  int                             cmp_count = 0;

  scrm_regmap #(.DEPTH(SHADOW_DEPTH)) dut (.core_clk_in, .rstn_in, .wr_en_in(wr_en),
    .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata),
    .rvalid_out(rvalid), .lsb_first_out(lsb_first), .soft_reset_out(soft_reset),
    .apply_done_out(apply_done), .feature_out(feature), .active_out(active));
  scrm_host_model host (.core_clk_in, .rdata_in(rdata), .rvalid_in(rvalid),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));

  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] act(input int i);
    return active[8*i +: 8];
  endfunction : act
  task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
    host.rd(a, rd_val);
    chk(rd_val, exp);
  endtask : rchk

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rchk(ADDR_PORT, 8'h18);
    rchk(ADDR_APPLY, 8'h00);
    rchk(ADDR_GRADE, 8'h10);
    rchk(9'h013, 8'h00);
    chk(act(0), 8'h80);
    chk(act(1), 8'h01);
    chk(act(6), 8'h04);
    chk(act(16), 8'hc0);
    chk({7'h0, lsb_first}, 8'h00);
  endtask : t_reset
  task automatic t_shadow();
    host.wr(9'h009, 8'h00);
    host.wr(9'h00b, 8'h05);
    rchk(9'h00b, 8'h05);
    chk(act(1), 8'h01);
    chk(act(3), 8'h00);
    host.wr(ADDR_APPLY, 8'h01);
    chk({7'h0, apply_done}, 8'h00);
    @(posedge core_clk_in);
    #1;
    chk({7'h0, apply_done}, 8'h01);
    @(posedge core_clk_in);
    #1;
    chk({7'h0, apply_done}, 8'h00);
    chk(act(1), 8'h00);
    chk(act(3), 8'h05);
    rchk(ADDR_APPLY, 8'h00);
  endtask : t_shadow
  // read-only id must ignore writes
  task automatic t_feature();
    host.wr(ADDR_FEATURE, 8'h3c);
    host.wr(ADDR_DEV_ID, 8'ha5);
    rchk(ADDR_FEATURE, 8'h3c);
    chk(feature, 8'h3c);
    rchk(ADDR_DEV_ID, DEV_ID_VALUE);
  endtask : t_feature
  task automatic t_order();
    host.wr(ADDR_PORT, 8'h42);
    chk({7'h0, lsb_first}, 8'h01);
    host.wr(ADDR_PORT, 8'h02);
    rchk(ADDR_PORT, 8'h5a);
    host.wr(ADDR_PORT, 8'h00);
    chk({7'h0, lsb_first}, 8'h00);
  endtask : t_order
  // each mirrored soft reset bit alone
  task automatic t_soft();
    logic [7:0] srst;
    for (int i = 0; i < 2; i++) begin
      srst = i ? 8'h20 : 8'h04;
      host.wr(9'h00b, 8'h07);
      host.wr(ADDR_APPLY, 8'h01);
      host.wr(ADDR_FEATURE, 8'h11);
      host.wr(ADDR_PORT, srst | 8'h02);
      chk({7'h0, soft_reset}, 8'h01);
      @(posedge core_clk_in);
      #1;
      chk({7'h0, soft_reset}, 8'h00);
      chk(act(3), 8'h00);
      chk(feature, 8'h00);
      chk({7'h0, lsb_first}, 8'h00);
      rchk(9'h00b, 8'h00);
      rchk(ADDR_PORT, 8'h18);
    end
  endtask : t_soft

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    rstn_in = 1'b0;
    repeat (20) @(posedge core_clk_in);
    #1;
    rstn_in = 1'b1;
    t_reset();
    t_shadow();
    t_feature();
    t_order();
    t_soft();
    end_of_test();
  end
  // watchdog, far beyond the 82 or so cycles needed
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
endmodule : shadowed_config_register_map_test
